// *** logic/lrm_bank.sv ***
// register bank: regulator irq masks and buck load measurement
`timescale 1ns/10ps
module lrm_bank import lrm_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  input wire lrm_live_s liveIn,
  input wire logic measReadyIrqMask,
  input wire logic [8:0] adcSample0,
  input wire logic [8:0] adcSample1,
  output logic measBuck1,
  output logic reg1PgIrqFlag,
  output logic reg1CurlimIrqFlag,
  output logic reg0PgIrqFlag,
  output logic reg0CurlimIrqFlag,
  output logic measReadyIrqFlag,
  output lrm_live_s linregLiveStatus
);

  logic [7:0] mask_q;
  logic [7:0] maskWr;
  logic [7:0] sel_q;
  logic [8:0] result;
  logic doneP;
  lrm_live_s live_q;
  logic [7:0] rd_q;
  logic [7:0] rd_d;

  logic r1pg_q;
  logic r1il_q;
  logic r0pg_q;
  logic r0il_q;
  logic mr_q;

  lrm_start_s startReq;
  logic wrSel;
  logic wrMask;

  logic r1PgInvalidEvt;
  logic r1PgValidEvt;
  logic r1CurlimEvt;
  logic r0PgInvalidEvt;
  logic r0PgValidEvt;
  logic r0CurlimEvt;
  logic r1PgReq;
  logic r1CurlimReq;
  logic r0PgReq;
  logic r0CurlimReq;
  logic measReadyReq;

  // one decode shared by every writable register
  function automatic logic hitWr(
    input logic en,
    input logic [7:0] addr,
    input logic [7:0] target
  );
    hitWr = en && (addr == target);
  endfunction : hitWr

  function automatic logic rose(
    input logic prev,
    input logic cur
  );
    rose = !prev && cur;
  endfunction : rose

  function automatic logic fell(
    input logic prev,
    input logic cur
  );
    fell = prev && !cur;
  endfunction : fell

  // a set mask bit stops the event; the live copy never sees it
  function automatic logic passEvt(
    input logic evt,
    input logic maskBit
  );
    passEvt = evt && !maskBit;
  endfunction : passEvt

  // reserved bits of mask and result and unmapped offsets read zero; sel reads back all eight written bits
  function automatic logic [7:0] rdMux(
    input logic [7:0] addr,
    input logic [7:0] maskVal,
    input logic [7:0] selVal,
    input logic [8:0] res
  );
    unique case (addr)
      ADDR_MASK: rdMux = maskVal;
      ADDR_SEL: rdMux = selVal;
      ADDR_RES_HI: rdMux = {7'h00, res[8]};
      ADDR_RES_LO: rdMux = res[7:0];
      default: rdMux = 8'h00;
    endcase
  endfunction : rdMux

  assign wrSel = hitWr(regWrEn, regAddr, ADDR_SEL);
  assign wrMask = hitWr(regWrEn, regAddr, ADDR_MASK);
  assign startReq = '{start: wrSel, buck: regWrData[B_SEL]};
  // reserved mask bits keep reading zero whatever is written
  assign maskWr = regWrData & MASK_WR;

  // edges against the registered copy give one event per pg change (rise or fall) or curlim rise
  assign r1PgInvalidEvt = fell(live_q.pg1, liveIn.pg1);
  assign r1PgValidEvt = rose(live_q.pg1, liveIn.pg1);
  assign r1CurlimEvt = rose(live_q.curlim1, liveIn.curlim1);
  assign r0PgInvalidEvt = fell(live_q.pg0, liveIn.pg0);
  assign r0PgValidEvt = rose(live_q.pg0, liveIn.pg0);
  assign r0CurlimEvt = rose(live_q.curlim0, liveIn.curlim0);

  assign r1PgReq = passEvt(r1PgInvalidEvt, mask_q[B_R1_PGF]) ||
    passEvt(r1PgValidEvt, mask_q[B_R1_PGR]);
  assign r1CurlimReq = passEvt(r1CurlimEvt, mask_q[B_R1_ILIM]);
  assign r0PgReq = passEvt(r0PgInvalidEvt, mask_q[B_R0_PGF]) ||
    passEvt(r0PgValidEvt, mask_q[B_R0_PGR]);
  assign r0CurlimReq = passEvt(r0CurlimEvt, mask_q[B_R0_ILIM]);
  assign measReadyReq = passEvt(doneP, measReadyIrqMask);

  always_ff @(posedge clk) begin
    if (rst) begin
      mask_q <= MASK_RST;
    end else if (wrMask) begin
      mask_q <= maskWr;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sel_q <= SEL_RST;
    end else if (wrSel) begin
      sel_q <= regWrData;
    end
  end

  lrm_meas_seq uSeq (
    .clk(clk),
    .rst(rst),
    .startReq(startReq),
    .adcSample0(adcSample0),
    .adcSample1(adcSample1),
    .measBuck1(measBuck1),
    .result(result),
    .doneP(doneP)
  );

  // live status passes untouched by any mask
  always_ff @(posedge clk) begin
    if (rst) begin
      live_q <= '0;
    end else begin
      live_q <= liveIn;
    end
  end

  // edges of live status and measurement done raise flags; read of flag register not mapped here,
  // so flags stay sticky until reset
  always_ff @(posedge clk) begin
    if (rst) begin
      r1pg_q <= 1'b0;
    end else if (r1PgReq) begin
      r1pg_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r1il_q <= 1'b0;
    end else if (r1CurlimReq) begin
      r1il_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r0pg_q <= 1'b0;
    end else if (r0PgReq) begin
      r0pg_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      r0il_q <= 1'b0;
    end else if (r0CurlimReq) begin
      r0il_q <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      mr_q <= 1'b0;
    end else if (measReadyReq) begin
      mr_q <= 1'b1;
    end
  end

  // read data holds until the next read strobe
  always_comb begin
    rd_d = rd_q;
    if (regRdEn) begin
      rd_d = rdMux(regAddr, mask_q, sel_q, result);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rd_q <= 8'h00;
    end else begin
      rd_q <= rd_d;
    end
  end

  assign regRdData = rd_q;
  assign reg1PgIrqFlag = r1pg_q;
  assign reg1CurlimIrqFlag = r1il_q;
  assign reg0PgIrqFlag = r0pg_q;
  assign reg0CurlimIrqFlag = r0il_q;
  assign measReadyIrqFlag = mr_q;
  assign linregLiveStatus = live_q;
endmodule : lrm_bank

// *** logic/lrm_meas_seq.sv ***
// measurement sequencer: converts raw adc sample to a latched result
`timescale 1ns/10ps
module lrm_meas_seq import lrm_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire lrm_start_s startReq,
  input wire logic [8:0] adcSample0,
  input wire logic [8:0] adcSample1,
  output logic measBuck1,
  output logic [8:0] result,
  output logic doneP
);
  lrm_state_e state_q;
  logic [11:0] cnt_q;
  logic buck_q;
  logic [8:0] res_q;
  logic done_q;
  function automatic logic [8:0] clampRes(input logic [8:0] raw);
    clampRes = (raw > RES_MAX) ? RES_MAX : raw;
  endfunction : clampRes
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= LRM_IDLE;
      cnt_q <= 12'h000;
      buck_q <= 1'b0;
    end else if (startReq.start) begin
      // a new write restarts even a running measurement
      state_q <= LRM_BUSY;
      cnt_q <= MEAS_CYC;
      buck_q <= startReq.buck;
    end else begin
      unique case (state_q)
        LRM_IDLE: begin
          state_q <= LRM_IDLE;
        end
        LRM_BUSY: begin
          cnt_q <= cnt_q - 12'h001;
          if (cnt_q == 12'h001) begin
            state_q <= LRM_IDLE;
          end
        end
        default: begin
          state_q <= LRM_IDLE;
        end
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      res_q <= RES_RST;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (!startReq.start && state_q == LRM_BUSY && cnt_q == 12'h001) begin
        res_q <= clampRes(buck_q ? adcSample1 : adcSample0);
        done_q <= 1'b1;
      end
    end
  end
  assign measBuck1 = buck_q;
  assign result = res_q;
  assign doneP = done_q;
endmodule : lrm_meas_seq

// *** logic/lrm_pkg.sv ***
// constants and types for the linear-regulator mask and load measurement bank
package lrm_pkg;
  localparam logic [7:0] ADDR_MASK = 8'h23;
  localparam logic [7:0] ADDR_SEL = 8'h24;
  localparam logic [7:0] ADDR_RES_HI = 8'h25;
  localparam logic [7:0] ADDR_RES_LO = 8'h26;
  localparam logic [7:0] MASK_RST = 8'hcc;
  localparam logic [7:0] MASK_WR = 8'hdd;
  localparam logic [7:0] SEL_RST = 8'h00;
  localparam logic [8:0] RES_RST = 9'h001;
  localparam int B_R1_PGF = 7;
  localparam int B_R1_PGR = 6;
  localparam int B_R1_ILIM = 4;
  localparam int B_R0_PGF = 3;
  localparam int B_R0_PGR = 2;
  localparam int B_R0_ILIM = 0;
  localparam int B_SEL = 0;
  localparam int LSB_MA = 20;
  localparam int FULL_MA = 10220;
  localparam logic [8:0] RES_MAX = 9'(FULL_MA / LSB_MA);
  localparam int MEAS_TIME_US = 20;
  localparam int CLK_MHZ = 50;
  localparam logic [11:0] MEAS_CYC = 12'(MEAS_TIME_US * CLK_MHZ);
  typedef struct packed {
    logic pg1;
    logic curlim1;
    logic pg0;
    logic curlim0;
  } lrm_live_s;
  typedef struct packed {
    logic start;
    logic buck;
  } lrm_start_s;
  typedef enum logic [1:0] {
    LRM_IDLE = 2'b01,
    LRM_BUSY = 2'b10
  } lrm_state_e;
endpackage : lrm_pkg

// *** tb/linreg_irq_mask_and_load_meas_test.sv ***
// self-checking bench for the mask and measurement register bank
`timescale 1ns/10ps
module linreg_irq_mask_and_load_meas_test import lrm_pkg::*;;
  logic clk = 1'b0, rst = 1'b1, wrEn = 1'b0, rdEn = 1'b0, rMask = 1'b1;
  logic [7:0] addr = 8'h00, wrData = 8'h00, rdData;
  logic [8:0] s0, s1;
  logic b1, p1, c1, p0, c0, rdy;
  lrm_live_s live = 4'h0, liveSt;
  int badCount = 0, nChecks = 0;
  always #10 clk = ~clk;
  lrm_analog model (.clk(clk), .adcSample0(s0), .adcSample1(s1));
  lrm_bank uut (.clk(clk), .rst(rst), .regWrEn(wrEn), .regRdEn(rdEn),
    .regAddr(addr), .regWrData(wrData), .regRdData(rdData), .liveIn(live),
    .measReadyIrqMask(rMask), .adcSample0(s0), .adcSample1(s1),
    .measBuck1(b1), .reg1PgIrqFlag(p1), .reg1CurlimIrqFlag(c1),
    .reg0PgIrqFlag(p0), .reg0CurlimIrqFlag(c0), .measReadyIrqFlag(rdy),
    .linregLiveStatus(liveSt));
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    nChecks++;
    if (got !== exp) begin
      badCount++;
      $display("wrong value at %0t: %h vs %h", $time, got, exp);
    end
  endtask : chk
  // expected register images from the rules, not from the design
  function automatic logic [7:0] maskExp(input logic [7:0] w);
    return w & MASK_WR;
  endfunction : maskExp
  function automatic logic [8:0] resExp(input logic [8:0] raw);
    return (raw > RES_MAX) ? RES_MAX : raw;
  endfunction : resExp
  // write or read-compare; idle edge after each avoids a double drive
  task automatic acc(input logic rd, input logic [7:0] a,
    input logic [7:0] v);
    addr = a;
    wrData = v;
    {wrEn, rdEn} = {!rd, rd};
    @(negedge clk);
    {wrEn, rdEn} = 2'b00;
    @(negedge clk);
    if (rd) chk({1'b0, rdData}, {1'b0, v});
  endtask : acc
  task automatic conclude();
    $display("checks %0d mismatches %0d", nChecks, badCount);
    if (badCount == 0 && nChecks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude
  initial begin
    #200us;
    badCount++;
    conclude();
  end
  initial begin
    void'($urandom(32'h2d6b));
    repeat (3) @(negedge clk);
    rst = 1'b0;
    acc(1, ADDR_MASK, MASK_RST);
    acc(1, ADDR_SEL, SEL_RST);
    acc(1, ADDR_RES_HI, 8'h00);
    acc(1, ADDR_RES_LO, RES_RST[7:0]);
    acc(1, 8'h27, 8'h00);
    for (int i = 0; i < 6; i++) begin
      acc(0, ADDR_MASK, (i != 0) ? 8'($urandom) : 8'hff);
      acc(1, ADDR_MASK, maskExp(wrData));
    end
    acc(0, ADDR_MASK, 8'h11);
    live = 4'h5;
    repeat (4) @(negedge clk);
    live = 4'hf;
    repeat (4) @(negedge clk);
    chk(9'({p1, c1, p0, c0}), 9'h00a);
    chk(9'(liveSt), 9'h00f);
    acc(0, ADDR_MASK, 8'h00);
    live = 4'h0;
    repeat (4) @(negedge clk);
    live = 4'h5;
    repeat (4) @(negedge clk);
    chk(9'({p1, c1, p0, c0}), 9'h00f);
    acc(0, ADDR_SEL, 8'h01);
    chk(9'(b1), 9'h001);
    repeat (1000) @(negedge clk);
    chk(9'(rdy), 9'h000);
    acc(1, ADDR_RES_HI, 8'(resExp(s1) >> 8));
    acc(1, ADDR_RES_LO, 8'(resExp(s1)));
    rMask = 1'b0;
    acc(0, ADDR_SEL, 8'h00);
    chk(9'(b1), 9'h000);
    repeat (500) @(negedge clk);
    acc(0, ADDR_SEL, 8'h00);
    repeat (600) @(negedge clk);
    chk(9'(rdy), 9'h000);
    acc(1, ADDR_RES_LO, s1[7:0]);
    repeat (400) @(negedge clk);
    chk(9'(rdy), 9'h001);
    acc(1, ADDR_RES_HI, 8'(resExp(s0) >> 8));
    acc(0, ADDR_RES_LO, 8'h55);
    acc(1, ADDR_RES_LO, 8'(resExp(s0)));
    // reset in mid-measurement; sticky flags start afresh
    acc(0, ADDR_SEL, 8'h01);
    live = 4'h0;
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    chk(9'({p1, c1, p0, c0, rdy}), 9'h000);
    chk(9'(b1), 9'h000);
    acc(1, ADDR_MASK, MASK_RST);
    acc(1, ADDR_RES_LO, RES_RST[7:0]);
    live = 4'ha;
    repeat (4) @(negedge clk);
    live = 4'h0;
    repeat (4) @(negedge clk);
    chk(9'({p1, c1, p0, c0}), 9'h000);
    acc(0, ADDR_MASK, 8'h44);
    live = 4'ha;
    repeat (4) @(negedge clk);
    chk(9'({p1, c1, p0, c0}), 9'h000);
    live = 4'h5;
    repeat (4) @(negedge clk);
    chk(9'({p1, c1, p0, c0}), 9'h00f);
    repeat (1000) @(negedge clk);
    chk(9'(rdy), 9'h000);
    conclude();
  end
endmodule : linreg_irq_mask_and_load_meas_test

// *** tb/lrm_analog.sv ***
// analog side model: load current codes of the two converters
`timescale 1ns/10ps
module lrm_analog import lrm_pkg::*; (
  input wire logic clk,
  output logic [8:0] adcSample0,
  output logic [8:0] adcSample1
);
  // held levels; real loads settle far slower than one measurement
  initial begin
    adcSample0 = 9'h000;
    adcSample1 = 9'h1ff;
    @(negedge clk);
    adcSample0 = 9'($urandom);
  end
endmodule : lrm_analog

// *** tb/lrm_monitor.sv ***
// checker for the mask and measurement register bank
`timescale 1ns/10ps
module lrm_monitor import lrm_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  input wire lrm_live_s liveIn,
  input wire logic measReadyIrqMask,
  input wire logic measBuck1,
  input wire logic reg1PgIrqFlag,
  input wire logic reg1CurlimIrqFlag,
  input wire logic reg0PgIrqFlag,
  input wire logic reg0CurlimIrqFlag,
  input wire logic measReadyIrqFlag,
  input wire lrm_live_s linregLiveStatus
);
  // shadow of the mask, since the checker cannot see inside
  logic [7:0] mask_q;
  always_ff @(posedge clk) begin
    if (rst) mask_q <= MASK_RST;
    else if (regWrEn && regAddr == ADDR_MASK) mask_q <= regWrData & MASK_WR;
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  a_live_copy: assert property (linregLiveStatus == $past(liveIn))
    else $error("live status differs");
  a_curlim0_flag: assert property ($rose(liveIn.curlim0) && !mask_q[0]
    |-> ##[1:3] reg0CurlimIrqFlag) else $error("curlim0 flag missing");
  a_curlim1_flag: assert property ($rose(liveIn.curlim1) && !mask_q[4]
    |-> ##[1:3] reg1CurlimIrqFlag) else $error("curlim1 flag missing");
  a_pg0_flag: assert property ($rose(liveIn.pg0) && !mask_q[2] ||
    $fell(liveIn.pg0) && !mask_q[3] |-> ##[1:3] reg0PgIrqFlag)
    else $error("pg0 flag missing");
  a_pg1_flag: assert property ($rose(liveIn.pg1) && !mask_q[6] ||
    $fell(liveIn.pg1) && !mask_q[7] |-> ##[1:3] reg1PgIrqFlag)
    else $error("pg1 flag missing");
  a_sel_buck: assert property (regWrEn && regAddr == ADDR_SEL
    |=> measBuck1 == $past(regWrData[0])) else $error("wrong buck");
  a_hi_zero: assert property (regRdEn && regAddr == ADDR_RES_HI
    |=> regRdData[7:1] == 7'h00) else $error("high result upper bits");
  a_ready_sticky: assert property (measReadyIrqFlag |=> measReadyIrqFlag)
    else $error("ready flag dropped");
  a_ready_gate: assert property ($rose(measReadyIrqFlag)
    |-> !$past(measReadyIrqMask)) else $error("ready flag while masked");
  a_curlim0_gate: assert property ($rose(reg0CurlimIrqFlag)
    |-> !$past(mask_q[0])) else $error("curlim0 flag while masked");
  c_ready: cover property ($rose(measReadyIrqFlag));
  c_curlim: cover property ($rose(reg0CurlimIrqFlag));
  c_pg: cover property ($rose(reg1PgIrqFlag));
endmodule : lrm_monitor
bind lrm_bank lrm_monitor mon (.*);
